// ---- logic/cor_pkg.sv ----
package cor_pkg;

  localparam int          COR_ADDR_W     = 8;
  localparam int          COR_DATA_W     = 8;

  localparam logic [7:0]  COR_OFS_REV    = 8'h09;
  localparam logic [7:0]  COR_OFS_OPT    = 8'h0a;
  localparam logic [7:0]  COR_OFS_ST1    = 8'h0b;
  localparam logic [7:0]  COR_OFS_ST2    = 8'h0c;

  localparam logic [7:0]  COR_REV_RST    = 8'hf6;
  localparam logic [3:0]  COR_VLIM_MAX   = 4'ha;

  localparam logic [11:0] COR_ILIM_OFS_MA  = 12'h1f4;
  localparam logic [11:0] COR_ILIM_STEP_MA = 12'h064;
  localparam logic [12:0] COR_VLIM_OFS_MV  = 13'h1194;
  localparam logic [12:0] COR_VLIM_STEP_MV = 13'h0064;

  typedef enum logic [2:0] {
    COR_CHG_IDLE   = 3'h0,
    COR_CHG_TRKL   = 3'h1,
    COR_CHG_PRE    = 3'h2,
    COR_CHG_CC     = 3'h3,
    COR_CHG_CV     = 3'h4,
    COR_CHG_TOPOFF = 3'h5,
    COR_CHG_DONE   = 3'h6,
    COR_CHG_RSVD   = 3'h7
  } cor_chg_t;

  typedef enum logic [2:0] {
    COR_SRC_NONE = 3'h0,
    COR_SRC_SDP  = 3'h1,
    COR_SRC_CDP  = 3'h2,
    COR_SRC_DCP  = 3'h3,
    COR_SRC_WEAK = 3'h4,
    COR_SRC_UNK  = 3'h5,
    COR_SRC_NSTD = 3'h6,
    COR_SRC_REV  = 3'h7
  } cor_src_t;

  typedef enum logic [1:0] {
    COR_OPT_OFF  = 2'h0,
    COR_OPT_BUSY = 2'h1,
    COR_OPT_DONE = 2'h2,
    COR_OPT_RSVD = 2'h3
  } cor_opt_t;

  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [COR_ADDR_W-1:0] addr;
    logic [COR_DATA_W-1:0] wdata;
  } cor_bus_t;

  typedef struct packed {
    logic [3:0] reverse_current_limit;
    logic [3:0] reverse_voltage_target;
  } cor_rev_t;

  typedef struct packed {
    logic [4:0] optimized_current_in_use;
    logic       input_current_reg_active;
    logic       input_voltage_reg_active;
    logic       thermal_reg_active;
    cor_chg_t   charge_state;
    logic       power_good_state;
    cor_src_t   input_source_type;
    cor_opt_t   optimizer_state;
    logic       min_system_reg_active;
  } cor_status_t;

  typedef struct packed {
    cor_status_t s1;
    cor_status_t s2;
    cor_status_t s3;
    cor_status_t view;
    cor_rev_t    rev;
    logic        wd_prev;
    logic [7:0]  rd_data;
    logic [3:0]  vlim_eff;
    logic [11:0] ilim_ma;
    logic [12:0] vreg_mv;
  } cor_state_t;

endpackage

// ---- logic/cor_regs.sv ----
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
// Function
// - reverse current limit code, 100 mA steps over 0.5 A, default 2.0 A
// - reverse voltage code, 100 mV steps over 4.5 V, default 5.1 V
// - voltage codes above ah act as 5.5 V target
// - reverse control register resets to f6h on reset, register reset, watchdog
// - optimized input current field reads 5-bit limit, 500 mA offset
// - reserved bits always read zero
// - input current regulation bit reads live limiting state
// - input voltage regulation bit reads live regulation state
// - thermal regulation bit reads live thermal loop state
// - watchdog bit reads one once host watchdog expired
// - charge state field reads 3-bit charge phase code
// - input source field reads 3-bit source detection code
// - optimizer state field reads 2-bit optimizer code
// - minimum system bit reads one while system rail held at minimum
module cor_regs
  import cor_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire cor_bus_t    bus,
  output logic [7:0]       rd_data_ff,
  input  wire cor_status_t status_in,
  input  wire logic        watchdog_expired,
  input  wire logic        reg_reset_req,
  output logic [3:0]       reverse_current_limit_ff,
  output logic [3:0]       reverse_voltage_target_ff,
  output logic [11:0]      reverse_current_ma_ff,
  output logic [12:0]      reverse_voltage_mv_ff
);

  cor_state_t st_ff;
  cor_state_t nxt_st;
  logic       wd_rise;

  assign wd_rise = watchdog_expired & ~st_ff.wd_prev;

  always_comb begin
    nxt_st = st_ff;
    // analog status crosses in; a word is taken only once two stages agree
    nxt_st.s1 = status_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    if (st_ff.s2 == st_ff.s3) begin
      nxt_st.view = st_ff.s3;
    end
    nxt_st.wd_prev = watchdog_expired;
    // only the control register takes writes; status offsets fall through
    if (bus.wr && bus.addr == COR_OFS_REV) begin
      nxt_st.rev = cor_rev_t'(bus.wdata);
    end
    // restore beats a write in the same cycle
    if (reg_reset_req || wd_rise) begin
      nxt_st.rev = cor_rev_t'(COR_REV_RST);
    end
    // stored code reads back as written; only the target is clamped
    if (st_ff.rev.reverse_voltage_target > COR_VLIM_MAX) begin
      nxt_st.vlim_eff = COR_VLIM_MAX;
    end else begin
      nxt_st.vlim_eff = st_ff.rev.reverse_voltage_target;
    end
    nxt_st.ilim_ma = 12'(COR_ILIM_OFS_MA
                     + COR_ILIM_STEP_MA * {8'h00, st_ff.rev.reverse_current_limit});
    nxt_st.vreg_mv = 13'(COR_VLIM_OFS_MV
                     + COR_VLIM_STEP_MV * {9'h000, st_ff.vlim_eff});
    nxt_st.rd_data = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        COR_OFS_REV: begin
          nxt_st.rd_data = st_ff.rev;
        end
        COR_OFS_OPT: begin
          nxt_st.rd_data = {3'h0, st_ff.view.optimized_current_in_use};
        end
        COR_OFS_ST1: begin
          nxt_st.rd_data = {1'b0,
                            st_ff.view.input_current_reg_active,
                            st_ff.view.input_voltage_reg_active,
                            st_ff.view.thermal_reg_active,
                            watchdog_expired,
                            st_ff.view.charge_state};
        end
        COR_OFS_ST2: begin
          nxt_st.rd_data = {st_ff.view.power_good_state,
                            st_ff.view.input_source_type,
                            1'b0,
                            st_ff.view.optimizer_state,
                            st_ff.view.min_system_reg_active};
        end
        default: begin
          nxt_st.rd_data = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_ff          <= '0;
      st_ff.rev      <= cor_rev_t'(COR_REV_RST);
      st_ff.vlim_eff <= COR_REV_RST[3:0];
      st_ff.ilim_ma  <= 12'h7d0;
      st_ff.vreg_mv  <= 13'h13ec;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data_ff                = st_ff.rd_data;
  assign reverse_current_limit_ff  = st_ff.rev.reverse_current_limit;
  assign reverse_voltage_target_ff = st_ff.rev.reverse_voltage_target;
  assign reverse_current_ma_ff     = st_ff.ilim_ma;
  assign reverse_voltage_mv_ff     = st_ff.vreg_mv;

  // checks; status reads are compared with the settled view word, the watchdog bit with the live input

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  logic rd_rev;
  logic rd_opt;
  logic rd_st1;
  logic rd_st2;

  assign rd_rev = bus.rd && bus.addr == COR_OFS_REV;
  assign rd_opt = bus.rd && bus.addr == COR_OFS_OPT;
  assign rd_st1 = bus.rd && bus.addr == COR_OFS_ST1;
  assign rd_st2 = bus.rd && bus.addr == COR_OFS_ST2;

  ilim_scale_a: assert property (
    ##2 reverse_current_ma_ff == 12'(COR_ILIM_OFS_MA
        + COR_ILIM_STEP_MA * {8'h00, $past(reverse_current_limit_ff)}))
    else $error("current limit scale wrong");

  vreg_scale_a: assert property (
    ##3 reverse_voltage_mv_ff == 13'(COR_VLIM_OFS_MV
        + COR_VLIM_STEP_MV * {9'h000, $past(st_ff.vlim_eff)}))
    else $error("voltage target scale wrong");

  vlim_clamp_a: assert property (
    bus.wr && bus.addr == COR_OFS_REV && bus.wdata[3:0] > COR_VLIM_MAX
    && !reg_reset_req && !wd_rise
    |=> ##1 st_ff.vlim_eff == COR_VLIM_MAX ##1 reverse_voltage_mv_ff == 13'h157c)
    else $error("voltage target not clamped");

  rev_restore_a: assert property (
    reg_reset_req || wd_rise |=> st_ff.rev == cor_rev_t'(COR_REV_RST))
    else $error("control register not restored");

  rev_write_a: assert property (
    bus.wr && bus.addr == COR_OFS_REV && !reg_reset_req && !wd_rise
    |=> st_ff.rev == cor_rev_t'($past(bus.wdata)))
    else $error("control write not stored");

  rev_read_a: assert property (
    rd_rev |=> rd_data_ff == $past(st_ff.rev))
    else $error("control read wrong");

  scale_default_a: assert property (
    $fell(reset) |-> reverse_current_ma_ff == 12'h7d0
    && reverse_voltage_mv_ff == 13'h13ec)
    else $error("scaled default wrong");

  ilim_range_a: assert property (
    reverse_current_ma_ff >= COR_ILIM_OFS_MA && reverse_current_ma_ff <= 12'h7d0)
    else $error("current limit out of range");

  vreg_range_a: assert property (
    reverse_voltage_mv_ff >= COR_VLIM_OFS_MV && reverse_voltage_mv_ff <= 13'h157c)
    else $error("voltage target out of range");

  vlim_pass_a: assert property (
    st_ff.rev.reverse_voltage_target <= COR_VLIM_MAX
    |=> st_ff.vlim_eff == $past(st_ff.rev.reverse_voltage_target))
    else $error("voltage code not passed");

  rev_default_a: assert property (
    $fell(reset) |-> reverse_current_limit_ff == 4'hf
    && reverse_voltage_target_ff == 4'h6)
    else $error("control default wrong");

  opt_read_a: assert property (
    rd_opt |=> rd_data_ff[4:0] == $past(st_ff.view.optimized_current_in_use))
    else $error("optimized current read wrong");

  rsvd_zero_a: assert property (
    rd_opt || rd_st1 || rd_st2 |=> (rd_data_ff & ($past(rd_opt) ? 8'he0 :
      $past(rd_st1) ? 8'h80 : 8'h08)) == 8'h00)
    else $error("reserved bit not zero");

  iin_read_a: assert property (
    rd_st1 |=> rd_data_ff[6] == $past(st_ff.view.input_current_reg_active))
    else $error("input current bit wrong");

  vin_read_a: assert property (
    rd_st1 |=> rd_data_ff[5] == $past(st_ff.view.input_voltage_reg_active))
    else $error("input voltage bit wrong");

  therm_read_a: assert property (
    rd_st1 |=> rd_data_ff[4] == $past(st_ff.view.thermal_reg_active))
    else $error("thermal bit wrong");

  wd_read_a: assert property (
    rd_st1 |=> rd_data_ff[3] == $past(watchdog_expired))
    else $error("watchdog bit wrong");

  chg_read_a: assert property (
    rd_st1 |=> rd_data_ff[2:0] == $past(st_ff.view.charge_state))
    else $error("charge state wrong");

  src_read_a: assert property (
    rd_st2 |=> rd_data_ff[6:4] == $past(st_ff.view.input_source_type))
    else $error("input source wrong");

  opt_state_a: assert property (
    rd_st2 |=> rd_data_ff[2:1] == $past(st_ff.view.optimizer_state))
    else $error("optimizer state wrong");

  minsys_read_a: assert property (
    rd_st2 |=> rd_data_ff[0] == $past(st_ff.view.min_system_reg_active))
    else $error("minimum system bit wrong");

  ro_write_a: assert property (
    bus.wr && bus.addr != COR_OFS_REV && !reg_reset_req && !wd_rise
    |=> $stable(st_ff.rev))
    else $error("status write changed control");

  status_settle_a: assert property (
    $stable(status_in) [*4] |=> st_ff.view == $past(status_in, 4))
    else $error("status not settled");

  unmapped_a: assert property (
    bus.rd && !(rd_rev || rd_opt || rd_st1 || rd_st2) |=> rd_data_ff == 8'h00)
    else $error("unmapped read not zero");

  // read data stands one cycle only, so stale bytes never leak to the host
  rd_idle_a: assert property (
    !bus.rd |=> rd_data_ff == 8'h00)
    else $error("idle read data not zero");

  sync_chain_a: assert property (
    1'b1 |=> st_ff.s2 == $past(st_ff.s1) && st_ff.s3 == $past(st_ff.s2))
    else $error("status stages not shifting");

  view_hold_a: assert property (
    st_ff.s2 != st_ff.s3 |=> $stable(st_ff.view))
    else $error("status view took unsettled word");

  write_read_c: cover property (
    bus.wr && bus.addr == COR_OFS_REV ##1 rd_rev);
  clamp_c: cover property (
    st_ff.rev.reverse_voltage_target > COR_VLIM_MAX);
  wd_restore_c: cover property (
    st_ff.rev != cor_rev_t'(COR_REV_RST) ##1 wd_rise);
  status_change_c: cover property (
    $changed(st_ff.view) ##1 rd_st1);
  restore_write_c: cover property (
    bus.wr && bus.addr == COR_OFS_REV && reg_reset_req);

endmodule // cor_regs

// ---- tb/test_cor_regs.sv ----
`timescale 1ns/1ps
module test_cor_regs
  import cor_pkg::*;
();
  logic        clk_sys;
  logic        reset;
  cor_bus_t    bus;
  logic [7:0]  rd_data_ff;
  cor_status_t status_in;
  cor_status_t st;
  logic        watchdog_expired;
  logic        reg_reset_req;
  logic [3:0]  ilim_q;
  logic [3:0]  vlim_q;
  logic [11:0] ma_q;
  logic [12:0] mv_q;
  logic [7:0]  rev_m;
  int          fails;
  int          num_checks;

  cor_regs uut (
    .clk_sys                   (clk_sys),
    .reset                     (reset),
    .bus                       (bus),
    .rd_data_ff                (rd_data_ff),
    .status_in                 (status_in),
    .watchdog_expired          (watchdog_expired),
    .reg_reset_req             (reg_reset_req),
    .reverse_current_limit_ff  (ilim_q),
    .reverse_voltage_target_ff (vlim_q),
    .reverse_current_ma_ff     (ma_q),
    .reverse_voltage_mv_ff     (mv_q)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // model of the register map; watchdog bit is live, not captured
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      COR_OFS_REV: return rev_m;
      COR_OFS_OPT: return {3'h0, st.optimized_current_in_use};
      COR_OFS_ST1: return {1'b0, st.input_current_reg_active, st.input_voltage_reg_active,
                           st.thermal_reg_active, watchdog_expired, st.charge_state};
      COR_OFS_ST2: return {st.power_good_state, st.input_source_type, 1'b0,
                           st.optimizer_state, st.min_system_reg_active};
      default:     return 8'h00;
    endcase
  endfunction

  task automatic chk_out(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // rr high raises register reset in the same cycle as the write
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic rr);
    @(posedge clk_sys);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    reg_reset_req <= rr;
    @(posedge clk_sys);
    bus.wr <= 1'b0;
    reg_reset_req <= 1'b0;
    if (a == COR_OFS_REV) rev_m = d;
    if (rr) rev_m = COR_REV_RST;
  endtask

  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] e;
    e = exp_rd(a);
    @(posedge clk_sys);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1;
    chk_out("rd_data_ff", {8'h00, e}, {8'h00, rd_data_ff});
  endtask

  // scaled outputs settle two edges after the edge that takes a write; three are waited
  task automatic rev_chk();
    int ie;
    int ve;
    repeat (3) @(posedge clk_sys);
    #1;
    ie = 500 + 100 * rev_m[7:4];
    ve = 4500 + 100 * ((rev_m[3:0] > 4'ha) ? 10 : rev_m[3:0]);
    chk_out("ilim code", {12'h000, rev_m[7:4]}, {12'h000, ilim_q});
    chk_out("vlim code", {12'h000, rev_m[3:0]}, {12'h000, vlim_q});
    chk_out("ilim ma", 16'(ie), {4'h0, ma_q});
    chk_out("vlim mv", 16'(ve), {3'h0, mv_q});
  endtask

  task automatic give_verdict();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    give_verdict();
  end

  initial begin
    logic [31:0] r;
    bus = '0;
    status_in = '0;
    st = '0;
    watchdog_expired = 1'b0;
    reg_reset_req = 1'b0;
    reset = 1'b1;
    fails = 0;
    num_checks = 0;
    rev_m = 8'hf6;
    void'($urandom(49));
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    rev_chk();
    rd_chk(COR_OFS_REV);
    for (int v = 0; v < 16; v++) begin
      wr(COR_OFS_REV, {4'($urandom), 4'(v)}, 1'b0);
      rev_chk();
      rd_chk(COR_OFS_REV);
    end
    // every charge, source and optimizer code; watchdog toggles each pass
    for (int i = 0; i < 8; i++) begin
      wr(COR_OFS_REV, 8'($urandom), 1'b0);
      r = $urandom;
      st = cor_status_t'(r[17:0]);
      st.charge_state = cor_chg_t'(i[2:0]);
      st.input_source_type = cor_src_t'(i[2:0]);
      st.optimizer_state = cor_opt_t'(i[1:0]);
      @(posedge clk_sys);
      status_in <= st;
      watchdog_expired <= i[0];
      if (i[0]) rev_m = COR_REV_RST;
      repeat (6) @(posedge clk_sys);
      rd_chk(COR_OFS_OPT);
      rd_chk(COR_OFS_ST1);
      rd_chk(COR_OFS_ST2);
      rd_chk(COR_OFS_REV);
    end
    wr(COR_OFS_OPT, 8'($urandom), 1'b0);
    wr(COR_OFS_ST1, 8'($urandom), 1'b0);
    wr(COR_OFS_ST2, 8'($urandom), 1'b0);
    wr(8'h20, 8'($urandom), 1'b0);
    rd_chk(COR_OFS_OPT);
    rd_chk(COR_OFS_ST1);
    rd_chk(COR_OFS_ST2);
    rd_chk(8'h20);
    // restore beats a write landing in the same cycle
    wr(COR_OFS_REV, 8'h12, 1'b1);
    rd_chk(COR_OFS_REV);
    wr(COR_OFS_REV, 8'h34, 1'b0);
    wr(8'hff, 8'h00, 1'b1);
    rev_chk();
    give_verdict();
  end
endmodule // test_cor_regs
